// ===== design/fc_dev.sv
// flash write/erase controller: registers, pair collector, sequencer
`timescale 1ns/1ps
module fc_dev #(
  parameter int TIMEOUT_CYC = fc_pkg::TIMEOUT_CYC,
  parameter int ERASE_UNITS = fc_pkg::ERASE_UNITS
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  fc_if.dev                bus,
  output      logic [13:0] flash_addr,
  output      logic [15:0] flash_wdata,
  input  wire logic [15:0] flash_rdata,
  output      logic        flash_prog,
  output      logic        flash_erase,
  output      logic        flash_read_cont,
  output      logic        access_violation
);
  typedef enum logic [1:0] {
    FC_IDLE,
    FC_ERASE,
    FC_COLLECT,
    FC_PROG
  } fc_state_t;

  fc_state_t   state_reg;
  logic [13:0] waddr_reg;
  logic [5:0]  timing_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  low_reg;
  logic        have_low_reg;
  logic        pend_wr_reg;
  logic        cont_reg;
  logic        from_flash_reg;
  logic [20:0] op_cnt_reg;
  logic [20:0] op_target_reg;
  logic [14:0] to_cnt_reg;
  logic [15:0] word_reg;
  logic        dma_req_reg;
  logic        hold_reg;
  logic        viol_reg;
  logic [7:0]  rdata_reg;
  logic        wr_ctl;
  logic        wr_data;
  logic        op_done;
  logic        timed_out;
  logic [20:0] unit_cyc;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  assign wr_ctl  = bus.sfr_wr && hit(bus.sfr_addr, fc_pkg::ADDR_FLASH_CONTROL);
  assign wr_data = bus.sfr_wr && hit(bus.sfr_addr, fc_pkg::ADDR_FLASH_WDATA);
  // one time unit is sixteen timing-field periods
  assign unit_cyc  = 21'(timing_reg) << fc_pkg::UNIT_SHIFT; // R14
  assign op_done   = (op_cnt_reg >= op_target_reg);
  assign timed_out = (to_cnt_reg >= 15'(TIMEOUT_CYC - 1));

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg    <= FC_IDLE;
      pend_wr_reg  <= 1'b0;
      have_low_reg <= 1'b0;
      low_reg      <= 8'h00;
      word_reg     <= 16'h0000;
      dma_req_reg  <= 1'b0;
    end
    else
    begin
      dma_req_reg <= 1'b0;
      case (state_reg)
        FC_IDLE:
        begin
          if (wr_ctl && bus.sfr_wdata[fc_pkg::CTL_ERASE])
          begin
            state_reg   <= FC_ERASE; // R7
            pend_wr_reg <= bus.sfr_wdata[fc_pkg::CTL_WRITE]; // R8
          end
          else if (wr_ctl && bus.sfr_wdata[fc_pkg::CTL_WRITE])
          begin
            state_reg    <= FC_COLLECT; // R5
            have_low_reg <= 1'b0; // R22
            dma_req_reg  <= 1'b1; // R13
          end
        end
        FC_ERASE:
        begin
          if (op_done)
          begin
            state_reg    <= pend_wr_reg ? FC_COLLECT : FC_IDLE; // R8
            dma_req_reg  <= pend_wr_reg; // R13
            have_low_reg <= 1'b0; // R22
            pend_wr_reg  <= 1'b0;
          end
        end
        FC_COLLECT:
        begin
          if (wr_data && have_low_reg)
          begin
            // R21: a one never sets a bit that is already zero
            word_reg     <= {bus.sfr_wdata, low_reg} & flash_rdata; // R1
            have_low_reg <= 1'b0;
            state_reg    <= FC_PROG; // R2
          end
          else if (wr_data)
          begin
            low_reg      <= bus.sfr_wdata; // R18
            have_low_reg <= 1'b1;
            dma_req_reg  <= 1'b1; // R13
          end
          else if (timed_out)
          begin
            state_reg    <= FC_IDLE; // R4
            have_low_reg <= 1'b0; // R22
          end
        end
        FC_PROG:
        begin
          if (op_done)
          begin
            state_reg   <= FC_COLLECT;
            dma_req_reg <= 1'b1; // R13
          end
        end
        default:
        begin
          state_reg <= FC_IDLE;
        end
      endcase
    end
  end

  // operation length and byte-pair deadline
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      op_cnt_reg    <= '0;
      op_target_reg <= '0;
      to_cnt_reg    <= '0;
    end
    else
    begin
      if (state_reg == FC_IDLE && wr_ctl)
      begin
        op_cnt_reg    <= '0;
        op_target_reg <= 21'(unit_cyc * 21'(ERASE_UNITS));
      end
      else if (state_reg == FC_COLLECT && wr_data && have_low_reg)
      begin
        op_cnt_reg    <= '0;
        op_target_reg <= unit_cyc;
      end
      else if (state_reg == FC_ERASE || state_reg == FC_PROG)
      begin
        op_cnt_reg <= op_cnt_reg + 1'b1;
      end
      // R3: deadline restarts at write start and at end of each word
      if (state_reg != FC_COLLECT)
      begin
        to_cnt_reg <= '0;
      end
      else if (!timed_out)
      begin
        to_cnt_reg <= to_cnt_reg + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waddr_reg  <= '0;
      timing_reg <= fc_pkg::TIMING_RESET; // R15
      wdata_reg  <= fc_pkg::WDATA_RESET;
      cont_reg   <= 1'b0;
    end
    else
    begin
      if (state_reg == FC_PROG && op_done)
      begin
        waddr_reg <= waddr_reg + 1'b1; // R19
      end
      else if (bus.sfr_wr && state_reg == FC_IDLE)
      begin
        if (hit(bus.sfr_addr, fc_pkg::ADDR_FLASH_ADDR_LO))
        begin
          waddr_reg[7:0] <= bus.sfr_wdata;
        end
        if (hit(bus.sfr_addr, fc_pkg::ADDR_FLASH_ADDR_HI))
        begin
          waddr_reg[13:8] <= bus.sfr_wdata[5:0];
        end
        if (hit(bus.sfr_addr, fc_pkg::ADDR_FLASH_TIMING))
        begin
          timing_reg <= bus.sfr_wdata[5:0]; // R14
        end
      end
      if (wr_ctl)
      begin
        cont_reg <= bus.sfr_wdata[fc_pkg::CTL_CONTINUOUS_READ_ENABLE]; // R17
      end
      if (wr_data && state_reg != FC_PROG)
      begin
        wdata_reg <= bus.sfr_wdata;
      end
    end
  end

  // fetch hold, violation flag and read data
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      from_flash_reg <= 1'b0;
      hold_reg       <= 1'b0;
      viol_reg       <= 1'b0;
      rdata_reg      <= 8'h00;
    end
    else
    begin
      if (state_reg == FC_IDLE && wr_ctl)
      begin
        from_flash_reg <= bus.exec_from_flash;
      end
      hold_reg <= from_flash_reg && (state_reg != FC_IDLE)
                  && !(state_reg == FC_COLLECT && timed_out); // R10
      // set wins over the clear by a new write command
      if (state_reg == FC_PROG && (bus.cpu_flash_rd || wr_data))
      begin
        viol_reg <= 1'b1; // R20
      end
      else if (wr_ctl)
      begin
        viol_reg <= 1'b0;
      end
      if (bus.sfr_rd)
      begin
        case (bus.sfr_addr)
          fc_pkg::ADDR_FLASH_CONTROL:
            rdata_reg <= {state_reg != FC_IDLE, state_reg == FC_PROG,
                          1'b0, cont_reg, 4'h0}; // R9 R2 R16
          fc_pkg::ADDR_FLASH_WDATA:   rdata_reg <= wdata_reg;
          fc_pkg::ADDR_FLASH_ADDR_HI: rdata_reg <= {2'b00, waddr_reg[13:8]};
          fc_pkg::ADDR_FLASH_ADDR_LO: rdata_reg <= waddr_reg[7:0];
          fc_pkg::ADDR_FLASH_TIMING:  rdata_reg <= {2'b00, timing_reg};
          default:                    rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.sfr_rdata    = rdata_reg;
  assign bus.dma_req      = dma_req_reg;
  assign bus.fetch_hold   = hold_reg;
  // R7: erase addresses the page, word bits ignored by the array
  assign flash_addr       = waddr_reg;
  assign flash_wdata      = word_reg;
  assign flash_prog       = (state_reg == FC_PROG);
  assign flash_erase      = (state_reg == FC_ERASE); // R6
  assign flash_read_cont  = cont_reg;
  assign access_violation = viol_reg;
endmodule // fc_dev

// ===== design/fc_fifo.sv
// byte fifo between the data source and the register writer
`timescale 1ns/1ps
module fc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             in_ready,
  output      logic             out_valid,
  output      logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rp_reg];

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop)
      begin
        rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // fc_fifo

// ===== design/fc_host.sv
// processor/dma side: sets up the controller and streams data bytes
`timescale 1ns/1ps
module fc_host #(
  parameter int CLK_MHZ = fc_pkg::CLK_MHZ,
  parameter int DEPTH   = 16
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  fc_if.host               bus,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [13:0] cmd_addr,
  input  wire logic        cmd_from_flash,
  output      logic        cmd_ready,
  output      logic        cmd_done,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output      logic        byte_ready,
  input  wire logic        flash_rd_req
);
  localparam int FWT_RAW = fc_pkg::TIMING_NUM * CLK_MHZ
                           / fc_pkg::TIMING_DEN_MHZ;
  localparam logic [5:0] FWT_VAL = (FWT_RAW > fc_pkg::TIMING_MAX) ?
      6'(fc_pkg::TIMING_MAX) : 6'(FWT_RAW);

  typedef enum logic [2:0] {
    FH_IDLE, FH_POLL, FH_ADDR_LO, FH_ADDR_HI, FH_TIMING, FH_CMD,
    FH_NOOP, FH_RUN
  } fh_state_t;

  fh_state_t   st_reg;
  logic [1:0]  kind_reg;
  logic [13:0] addr_reg;
  logic        wr_reg;
  logic        rd_reg;
  logic        rd_wait_reg;
  logic [7:0]  a_reg;
  logic [7:0]  d_reg;
  logic        ff_reg;
  logic        frd_reg;
  logic        req_reg;
  logic        done_reg;
  logic        fifo_valid;
  logic [7:0]  fifo_data;
  logic        fifo_pop;
  logic        fifo_in_ready;
  logic        busy_seen;

  fc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (byte_valid),
    .in_data   (byte_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  assign byte_ready = fifo_in_ready;
  // R2: a byte goes out only on a request, never while word busy
  assign fifo_pop  = (st_reg == FH_RUN) && req_reg && fifo_valid
                     && !wr_reg;
  assign busy_seen = bus.sfr_rdata[fc_pkg::CTL_BUSY];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg      <= FH_IDLE;
      kind_reg    <= 2'b00;
      addr_reg    <= '0;
      wr_reg      <= 1'b0;
      rd_reg      <= 1'b0;
      rd_wait_reg <= 1'b0;
      a_reg       <= 8'h00;
      d_reg       <= 8'h00;
      req_reg     <= 1'b0;
      done_reg    <= 1'b0;
    end
    else
    begin
      wr_reg      <= 1'b0;
      rd_reg      <= 1'b0;
      done_reg    <= 1'b0;
      rd_wait_reg <= rd_reg;
      if (bus.dma_req)
      begin
        req_reg <= 1'b1;
      end
      else if (fifo_pop)
      begin
        req_reg <= 1'b0;
      end
      case (st_reg)
        FH_IDLE:
        begin
          if (cmd_valid)
          begin
            kind_reg <= cmd_kind;
            addr_reg <= cmd_addr; // R5
            req_reg  <= 1'b0;
            st_reg   <= FH_POLL;
          end
        end
        FH_POLL, FH_NOOP:
        begin
          if (rd_wait_reg && !busy_seen)
          begin
            st_reg   <= (st_reg == FH_POLL) ? FH_ADDR_LO : FH_IDLE;
            done_reg <= (st_reg == FH_NOOP);
          end
          else if (!rd_reg && !rd_wait_reg && !wr_reg)
          begin
            rd_reg <= 1'b1; // R9
            a_reg  <= fc_pkg::ADDR_FLASH_CONTROL;
          end
        end
        FH_ADDR_LO, FH_ADDR_HI, FH_TIMING:
        begin
          wr_reg <= 1'b1;
          a_reg  <= (st_reg == FH_ADDR_LO) ? fc_pkg::ADDR_FLASH_ADDR_LO :
                    (st_reg == FH_ADDR_HI) ? fc_pkg::ADDR_FLASH_ADDR_HI :
                    fc_pkg::ADDR_FLASH_TIMING;
          d_reg  <= (st_reg == FH_ADDR_LO) ? addr_reg[7:0] :
                    (st_reg == FH_ADDR_HI) ? {2'b00, addr_reg[13:8]} :
                    {2'b00, FWT_VAL}; // R14
          st_reg <= (st_reg == FH_ADDR_LO) ? FH_ADDR_HI :
                    (st_reg == FH_ADDR_HI) ? FH_TIMING : FH_CMD;
        end
        FH_CMD:
        begin
          wr_reg <= 1'b1;
          a_reg  <= fc_pkg::ADDR_FLASH_CONTROL;
          d_reg  <= 8'h00;
          d_reg[fc_pkg::CTL_WRITE] <= (kind_reg != 2'(fc_pkg::FC_ERASE_CMD));
          d_reg[fc_pkg::CTL_ERASE] <= (kind_reg != 2'(fc_pkg::FC_WR_CMD));
          // R11: an erase is followed by an idle bus cycle
          st_reg <= (kind_reg == 2'(fc_pkg::FC_ERASE_CMD)) ? FH_NOOP
                                                             : FH_RUN;
        end
        FH_RUN:
        begin
          if (fifo_pop)
          begin
            wr_reg <= 1'b1; // R3
            a_reg  <= fc_pkg::ADDR_FLASH_WDATA;
            d_reg  <= fifo_data;
          end
          else if (rd_wait_reg && !busy_seen)
          begin
            st_reg   <= FH_IDLE; // R4
            done_reg <= 1'b1;
          end
          else if (!rd_reg && !rd_wait_reg && !wr_reg)
          begin
            rd_reg <= 1'b1;
            a_reg  <= fc_pkg::ADDR_FLASH_CONTROL;
          end
        end
        default:
        begin
          st_reg <= FH_IDLE;
        end
      endcase
    end
  end

  // fetch-side signals: no flash read while the controller holds fetch
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ff_reg  <= 1'b0;
      frd_reg <= 1'b0;
    end
    else
    begin
      ff_reg  <= cmd_from_flash;
      frd_reg <= flash_rd_req && !bus.fetch_hold; // R10 R20
    end
  end

  assign bus.sfr_wr          = wr_reg;
  assign bus.sfr_rd          = rd_reg;
  assign bus.sfr_addr        = a_reg;
  assign bus.sfr_wdata       = d_reg;
  assign bus.exec_from_flash = ff_reg;
  assign bus.cpu_flash_rd    = frd_reg;
  assign cmd_ready           = (st_reg == FH_IDLE);
  assign cmd_done            = done_reg;
endmodule // fc_host

// ===== design/fc_if.sv
// special-function-register link between processor side and controller
`timescale 1ns/1ps
interface fc_if;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       dma_req;
  logic       exec_from_flash;
  logic       cpu_flash_rd;
  logic       fetch_hold;
  modport dev (
    input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata, exec_from_flash,
           cpu_flash_rd,
    output sfr_rdata, dma_req, fetch_hold
  );
  modport host (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, exec_from_flash,
           cpu_flash_rd,
    input  sfr_rdata, dma_req, fetch_hold
  );
endinterface

// ===== design/fc_pkg.sv
// constants shared by both ends of the flash write/erase controller link
//
// Overview of operation
// R1: each two data bytes program one word
// R2: word busy flag bit 6; no writes meanwhile
// R3: writer delivers byte pairs within 40 us
// R4: missed deadline ends write, address kept
// R5: new write resumes at retained failure address
// R6: erased page reads all ones
// R7: erase command erases page from high bits 5:1
// R8: erase plus write: erase finishes first
// R9: control bit 7 busy during any operation
// R10: hold flash fetch until operation completes
// R11: software follows erase command with no-op
// R12: watchdog interval must exceed 20 ms erase
// R13: write start and free register request DMA
// R14: timing field equals 21000 F over 16e9; host clamps it to TIMING_MAX, so writes 63 at 200 MHz
// R15: timing field resets to 0x11
// R16: command bits read zero, cleared after sleep
// R17: control bit 4 selects continuous read
// R18: first byte is word low byte
// R19: 14-bit word address, 512 words per page
// R20: flash access during word busy is violation
// R21: programming only clears bits
// R22: pair collector restarts on start or timeout
package fc_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_FLASH_TIMING  = 8'hAB;
  localparam logic [7:0] ADDR_FLASH_ADDR_LO = 8'hAC;
  localparam logic [7:0] ADDR_FLASH_ADDR_HI = 8'hAD;
  localparam logic [7:0] ADDR_FLASH_CONTROL = 8'hAE;
  localparam logic [7:0] ADDR_FLASH_WDATA   = 8'hAF;
  // ---------------------------------------------------------------
  // control fields and reset values
  // ---------------------------------------------------------------
  localparam int CTL_BUSY     = 7;
  localparam int CTL_WBUSY    = 6;
  localparam int CTL_CONTINUOUS_READ_ENABLE   = 4;
  localparam int CTL_WRITE    = 1;
  localparam int CTL_ERASE    = 0;
  localparam int WADDR_W      = 14;
  localparam int PAGE_WORD_W  = 9;
  localparam int TIMING_W     = 6;
  localparam logic [5:0] TIMING_RESET = 6'h11;
  localparam logic [7:0] WDATA_RESET  = 8'h00;
  localparam logic [4:0] DMA_DMA_EVENT_SELECT_FLASH = 5'h12;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int TIMEOUT_US     = 40;
  localparam int TIMEOUT_CYC    = TIMEOUT_US * CLK_MHZ;
  localparam int ERASE_MS       = 20;
  localparam int UNIT_SHIFT     = 4;
  localparam int ERASE_UNITS    = 1000;
  localparam int TIMING_NUM     = 21000;
  localparam int TIMING_DEN_MHZ = 16000;
  localparam int TIMING_MAX     = 63;
  typedef enum logic [1:0] {
    FC_WR_CMD,
    FC_ERASE_CMD,
    FC_BOTH_CMD
  } fc_cmd_t;
endpackage

// ===== dv/fc_assertions.sv
// concurrent checks on the processor-to-controller link
`timescale 1ns/1ps
module fc_assertions (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       dma_req,
  input wire logic       exec_from_flash,
  input wire logic       fetch_hold
);
  localparam int TRAW = fc_pkg::TIMING_NUM * fc_pkg::CLK_MHZ
                        / fc_pkg::TIMING_DEN_MHZ;
  localparam logic [7:0] TIMING_EXP = (TRAW > fc_pkg::TIMING_MAX) ?
                                      8'h3F : TRAW[7:0];
  logic       data_wr;
  logic       ctl_rd;
  logic [3:0] credit_reg;
  logic [3:0] credit_next;
  // ---------------------------------------------------------------
  // helper: data bytes requested by the controller and not yet written
  // ---------------------------------------------------------------
  assign data_wr = sfr_wr && (sfr_addr == fc_pkg::ADDR_FLASH_WDATA);
  assign ctl_rd  = sfr_rd && (sfr_addr == fc_pkg::ADDR_FLASH_CONTROL);
  always_comb
  begin
    credit_next = credit_reg;
    if (dma_req && !data_wr && credit_reg != 4'hF)
      credit_next = credit_reg + 4'h1;
    else if (!dma_req && data_wr && credit_reg != 4'h0)
      credit_next = credit_reg - 4'h1;
  end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      credit_reg <= 4'h0;
    else
      credit_reg <= credit_next;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence ctl_wr(c);
    sfr_wr && sfr_addr == fc_pkg::ADDR_FLASH_CONTROL && sfr_wdata[1:0] == c;
  endsequence
  a_write_first_dma: assert property (ctl_wr(2'b10) |=> dma_req)
    else $error("no request after write command");
  a_erase_before_dma: assert property (ctl_wr(2'b11) |=> !dma_req [*8])
    else $error("request during erase");
  a_dma_one_pulse: assert property (dma_req |=> !dma_req)
    else $error("request longer than one cycle");
  a_hold_on_cmd: assert property ((ctl_wr(2'b01) or ctl_wr(2'b10)
    or ctl_wr(2'b11)) ##0 exec_from_flash |-> ##2 fetch_hold)
    else $error("fetch not held");
  a_hold_needs_flash: assert property ($rose(fetch_hold) |-> exec_from_flash)
    else $error("fetch held for code in ram");
  a_busy_in_write: assert property (ctl_rd && dma_req |=> sfr_rdata[7])
    else $error("busy low during write");
  a_ctl_zero_bits: assert property (ctl_rd |=> sfr_rdata[5] == 1'b0
    && sfr_rdata[3:0] == 4'h0)
    else $error("command bits read nonzero");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without read");
  a_timing_value: assert property (sfr_wr && sfr_addr ==
    fc_pkg::ADDR_FLASH_TIMING |-> sfr_wdata == TIMING_EXP)
    else $error("timing field wrong");
  a_data_paced: assert property (data_wr |-> credit_reg != 4'h0)
    else $error("data byte without request");
  a_erase_bus_gap: assert property ((ctl_wr(2'b01) or ctl_wr(2'b11))
    |=> !sfr_wr && !sfr_rd) else $error("bus busy after erase");
endmodule // fc_assertions

// ===== dv/testbench.sv
// self-checking bench: host and controller joined by the link
`timescale 1ns/1ps
module testbench;
  logic        clk            = 1'b0;
  logic        arst_n         = 1'b0;
  logic        cmd_valid      = 1'b0;
  logic [1:0]  cmd_kind       = 2'd0;
  logic [13:0] cmd_addr       = 14'h0000;
  logic        cmd_from_flash = 1'b0;
  logic        byte_valid     = 1'b0;
  logic [7:0]  byte_data      = 8'h00;
  logic        flash_rd_req   = 1'b0;
  logic        cmd_ready, cmd_done, byte_ready;
  logic [13:0] flash_addr, a;
  logic [15:0] flash_wdata, flash_rdata, ov;
  logic        flash_prog, flash_erase, flash_read_cont, access_violation;
  logic [15:0] mem [0:16383];
  logic [7:0]  bq [$];
  logic [15:0] old_q [$];
  logic        erase_q = 1'b0;
  logic        hold_seen = 1'b0;
  logic        rd_arm = 1'b0;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          seed = 32'hE07E;
  fc_if bus_if ();
  fc_host #(.CLK_MHZ(fc_pkg::CLK_MHZ), .DEPTH(16)) fc_host_i (
    .clk(clk), .arst_n(arst_n), .bus(bus_if.host), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_from_flash(cmd_from_flash), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .flash_rd_req(flash_rd_req));
  fc_dev #(.TIMEOUT_CYC(200), .ERASE_UNITS(4)) fc_dev_i (
    .clk(clk), .arst_n(arst_n), .bus(bus_if.dev), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
    .flash_prog(flash_prog), .flash_erase(flash_erase),
    .flash_read_cont(flash_read_cont),
    .access_violation(access_violation));
  fc_assertions fc_assertions_i (
    .clk(clk), .arst_n(arst_n), .sfr_wr(bus_if.sfr_wr),
    .sfr_rd(bus_if.sfr_rd), .sfr_addr(bus_if.sfr_addr),
    .sfr_wdata(bus_if.sfr_wdata), .sfr_rdata(bus_if.sfr_rdata),
    .dma_req(bus_if.dma_req), .exec_from_flash(bus_if.exec_from_flash),
    .fetch_hold(bus_if.fetch_hold));
  // ---------------------------------------------------------------
  // clock, flash array model, watchdog
  // ---------------------------------------------------------------
  always #2.5 clk = ~clk;
  assign flash_rdata = mem[flash_addr];
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    erase_q <= flash_erase;
    flash_rd_req <= rd_arm && flash_prog;
    if (bus_if.fetch_hold === 1'b1)
      hold_seen <= 1'b1;
    if (flash_erase && !erase_q)
      for (int i = 0; i < 512; i++)
        mem[{flash_addr[13:9], 9'(i)}] <= 16'hFFFF;
    if (flash_prog)
      mem[flash_addr] <= flash_wdata;
    if (cyc == 80000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [15:0] exp_word(input logic [7:0] lo, hi,
                                           input logic [15:0] old);
    return {hi, lo} & old;
  endfunction
  task automatic check(input logic [15:0] seen, exp, input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s %h not %h", $time, msg, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic run_cmd(input logic [1:0] kind, input logic [13:0] ad,
                         input logic ff);
    int n;
    hold_seen = 1'b0;
    cmd_valid <= 1'b1;
    cmd_kind <= kind;
    cmd_addr <= ad;
    cmd_from_flash <= ff;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (cmd_done !== 1'b1 && n < 30000);
    check(16'(cmd_done), 16'h0001, "done");
    check(16'(hold_seen), 16'(ff), "fetch hold");
  endtask
  task automatic do_write(input logic [1:0] kind, input int n,
                          input logic ff, odd, viol);
    bq.delete();
    old_q.delete();
    for (int i = 0; i < 2 * n + odd; i++)
      bq.push_back(8'($random(seed)));
    for (int i = 0; i <= n; i++)
      old_q.push_back(kind == 2'd2 ? 16'hFFFF : mem[a + 14'(i)]);
    foreach (bq[i])
    begin
      byte_valid <= 1'b1;
      byte_data <= bq[i];
      do @(posedge clk); while (byte_ready !== 1'b1);
    end
    byte_valid <= 1'b0;
    if (n == 8)
    begin
      @(posedge clk);
      check(16'(byte_ready), 16'h0000, "fifo full");
    end
    rd_arm = viol;
    run_cmd(kind, a, ff);
    rd_arm = 1'b0;
    for (int i = 0; i < n; i++)
      check(mem[a + 14'(i)], exp_word(bq[2*i], bq[2*i+1], old_q[i]), "word");
    check(mem[a + 14'(n)], old_q[n], "lone byte");
    check(16'(flash_addr), 16'(a + 14'(n)), "fail address");
    check(16'(access_violation), 16'(viol), "violation");
    check(16'(byte_ready), 16'h0001, "fifo drained");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    for (int i = 0; i < 16384; i++)
      mem[i] = 16'($random(seed));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check(16'(flash_read_cont), 16'h0000, "continuous read");
    for (int k = 0; k < 3; k++)
    begin
      a = {5'($random(seed)), 9'($random(seed) & 32'h1F7)};
      do_write(2'd2, 3 + k, 1'b0, 1'b0, 1'b0);
      $display("erase and write %0d done", k);
    end
    do_write(2'd0, 7, 1'b1, 1'b1, 1'b0);
    $display("overwrite with lone byte done");
    a = a ^ 14'h0400;
    do_write(2'd0, 8, 1'b0, 1'b0, 1'b0);
    $display("full fifo write done");
    do_write(2'd0, 1, 1'b0, 1'b0, 1'b1);
    $display("violation write done");
    ov = mem[a ^ 14'h0200];
    run_cmd(2'd1, a, 1'b1);
    for (int i = 0; i < 512; i++)
      check(mem[{a[13:9], 9'(i)}], 16'hFFFF, "erased");
    check(mem[a ^ 14'h0200], ov, "other page");
    $display("page erase done");
    finish_test();
  end
endmodule // testbench
